/* File: include/caf_consts.vh */
`ifndef CAF_CONSTS_VH
`define CAF_CONSTS_VH

// ==========================================================
// bank geometry
`define CAF_NUM_BANKS 28
`define CAF_LAST_BANK 5'h1B
`define CAF_IDX_W 7
`define CAF_Q_DEPTH 2'h3

// ==========================================================
// 32-bit filter word fields
`define CAF_SFID32_HI 31
`define CAF_SFID32_LO 21
`define CAF_EFID32_HI 20
`define CAF_EFID32_LO 3
`define CAF_FF32_POS 2
`define CAF_FT32_POS 1
`define CAF_ZERO32_POS 0

// ==========================================================
// 16-bit filter half-word fields
`define CAF_EXTENDED_IDENTIFIER_TOP_HI 20
`define CAF_EXTENDED_IDENTIFIER_TOP_LO 18

// ==========================================================
// filter numbers consumed per bank configuration
`define CAF_USE_32_MASK 3'h1
`define CAF_USE_32_LIST 3'h2
`define CAF_USE_16_MASK 3'h2
`define CAF_USE_16_LIST 3'h4

`endif

/* File: rtl/caf_filter_mem.v */
`timescale 1ns/1ps
`include "caf_consts.vh"

module caf_filter_mem (
  input wire sys_clk,
  input wire wr_en,
  input wire [4:0] wr_bank,
  input wire wr_word,
  input wire [31:0] wr_data,
  input wire [4:0] rd_bank,
  output reg [31:0] rd_word_first,
  output reg [31:0] rd_word_second
);

  reg [31:0] mem_first [0:`CAF_NUM_BANKS-1];
  reg [31:0] mem_second [0:`CAF_NUM_BANKS-1];

  // ==========================================================
  // two filter words per bank, registered read
  always @(posedge sys_clk) begin
    if (wr_en && (wr_bank <= `CAF_LAST_BANK)) begin
      if (wr_word) begin
        mem_second[wr_bank] <= wr_data;
      end else begin
        mem_first[wr_bank] <= wr_data;
      end
    end
    rd_word_first <= mem_first[rd_bank];
    rd_word_second <= mem_second[rd_bank];
  end

endmodule // caf_filter_mem

/* File: rtl/caf_filter_top.v */
// Contract
// - Each bank is routed to queue zero or one and its accepted frames go only there.
// - Only activated banks take part in acceptance; unused banks should stay deactivated.
// - Every accepted frame carries the number of the filter that accepted it.
// - Each queue shows the filter number of its head frame in its status field.
// - Filter numbers run per queue and count every bank of that queue, active or not.
// - A matching 32-bit scale filter beats a matching 16-bit scale filter.
// - At equal scale a list-mode filter beats a mask-mode filter.
// - At equal scale and mode the lowest filter number wins and is recorded.
// - Each bank holds two 32-bit filter words and is set to 32-bit or 16-bit scale.
// - The 32-bit word holds standard id, extended id, format, type and a zero bit.
// - In 32-bit mask mode the first word is the identifier and the second a must-match mask; at 16-bit scale each word is an id/mask pair.
// - In list mode every word (every half-word at 16-bit scale) is an identifier that must match exactly.
`timescale 1ns/1ps
`include "caf_consts.vh"

module caf_filter_top (
  input wire sys_clk,
  input wire resetn,
  input wire cfg_wr_en,
  input wire [4:0] cfg_wr_bank,
  input wire cfg_wr_word,
  input wire [31:0] cfg_wr_data,
  input wire [27:0] bank_scale_32,
  input wire [27:0] bank_list_mode,
  input wire [27:0] bank_to_queue_one,
  input wire [27:0] bank_active,
  input wire frame_valid,
  output wire frame_ready,
  input wire [10:0] standard_identifier,
  input wire [17:0] extended_identifier,
  input wire frame_format_bit,
  input wire frame_type_bit,
  output reg accept_valid,
  output reg accept_queue,
  output reg [6:0] accept_index,
  output reg reject_valid,
  input wire [1:0] queue_release,
  output wire [8:0] rx_fifo_status_q0,
  output wire [8:0] rx_fifo_status_q1,
  output wire [1:0] queue_overrun
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SCAN = 2'h1;
  localparam ST_DRAIN = 2'h2;
  localparam ST_FINISH = 2'h3;

  // ==========================================================
  // reset release
  reg rst_meta_reg, rst_sync_reg;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  // ==========================================================
  // match functions
  function match32;
    input [31:0] fw;
    input [31:0] id;
    input [31:0] mask;
    begin
      match32 = (((fw ^ id) & mask) == 32'h00000000);
    end
  endfunction
  function match16;
    input [15:0] fw;
    input [15:0] id;
    input [15:0] mask;
    begin
      match16 = (((fw ^ id) & mask) == 16'h0000);
    end
  endfunction

  // ==========================================================
  // state
  reg [1:0] state_reg, best_cls_reg;
  reg [4:0] scan_reg, pipe_bank_reg;
  reg pipe_vld_reg, best_vld_reg, best_queue_reg;
  reg [31:0] fw32_reg;
  reg [6:0] num0_reg, num1_reg, best_idx_reg;
  wire [31:0] w_first, w_second;
  wire [15:0] fw16;
  assign frame_ready = (state_reg == ST_IDLE);
  assign fw16 = {fw32_reg[`CAF_SFID32_HI:`CAF_SFID32_LO], fw32_reg[`CAF_FT32_POS],
                 fw32_reg[`CAF_FF32_POS], fw32_reg[`CAF_EXTENDED_IDENTIFIER_TOP_HI:`CAF_EXTENDED_IDENTIFIER_TOP_LO]};

  caf_filter_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(cfg_wr_en),
    .wr_bank(cfg_wr_bank),
    .wr_word(cfg_wr_word),
    .wr_data(cfg_wr_data),
    .rd_bank(scan_reg),
    .rd_word_first(w_first),
    .rd_word_second(w_second)
  );

  // ==========================================================
  // 16-bit list halves
  wire [3:0] l16_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_half
      wire [31:0] src = (gi < 2) ? w_first : w_second;
      wire [15:0] half = src[16*(gi%2)+15 -: 16];
      assign l16_hit[gi] = match16(fw16, half, 16'hFFFF);
    end
  endgenerate

  // ==========================================================
  // bank evaluation
  reg b_scale, b_list, b_queue, b_act, cand_hit, better;
  reg [3:0] hit;
  reg [1:0] off;
  reg [2:0] use_cnt;
  reg [6:0] base, cand_idx;
  always @* begin
    b_scale = bank_scale_32[pipe_bank_reg];
    b_list = bank_list_mode[pipe_bank_reg];
    b_queue = bank_to_queue_one[pipe_bank_reg];
    b_act = bank_active[pipe_bank_reg];
    hit = 4'h0;
    use_cnt = `CAF_USE_16_MASK;
    case ({b_scale, b_list})
      2'b10: begin
        hit[0] = match32(fw32_reg, w_first, w_second);
        use_cnt = `CAF_USE_32_MASK;
      end
      2'b11: begin
        hit[0] = match32(fw32_reg, w_first, 32'hFFFFFFFF);
        hit[1] = match32(fw32_reg, w_second, 32'hFFFFFFFF);
        use_cnt = `CAF_USE_32_LIST;
      end
      2'b00: begin
        // low half id, high half mask
        hit[0] = match16(fw16, w_first[15:0], w_first[31:16]);
        hit[1] = match16(fw16, w_second[15:0], w_second[31:16]);
        use_cnt = `CAF_USE_16_MASK;
      end
      default: begin
        hit = l16_hit;
        use_cnt = `CAF_USE_16_LIST;
      end
    endcase
    off = hit[0] ? 2'h0 : (hit[1] ? 2'h1 : (hit[2] ? 2'h2 : 2'h3));
    base = b_queue ? num1_reg : num0_reg;
    cand_idx = base + {5'h00, off};
    cand_hit = pipe_vld_reg & b_act & (hit != 4'h0);
    better = cand_hit & (~best_vld_reg | ({b_scale, b_list} > best_cls_reg) |
             (({b_scale, b_list} == best_cls_reg) && (cand_idx < best_idx_reg)));
  end

  // ==========================================================
  // scan control
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      scan_reg <= 5'h00;
      pipe_vld_reg <= 1'b0;
      pipe_bank_reg <= 5'h00;
      fw32_reg <= 32'h00000000;
      num0_reg <= 7'h00;
      num1_reg <= 7'h00;
      best_vld_reg <= 1'b0;
      best_cls_reg <= 2'h0;
      best_queue_reg <= 1'b0;
      best_idx_reg <= 7'h00;
      accept_valid <= 1'b0;
      accept_queue <= 1'b0;
      accept_index <= 7'h00;
      reject_valid <= 1'b0;
    end else begin
      accept_valid <= 1'b0;
      reject_valid <= 1'b0;
      if (pipe_vld_reg) begin
        if (b_queue) begin
          num1_reg <= num1_reg + {4'h0, use_cnt};
        end else begin
          num0_reg <= num0_reg + {4'h0, use_cnt};
        end
      end
      if (better) begin
        best_vld_reg <= 1'b1;
        best_cls_reg <= {b_scale, b_list};
        best_queue_reg <= b_queue;
        best_idx_reg <= cand_idx;
      end
      case (state_reg)
        ST_IDLE: begin
          if (frame_valid) begin
            // frame word with zero low bit
            fw32_reg <= {standard_identifier, extended_identifier,
                         frame_format_bit, frame_type_bit, 1'b0};
            scan_reg <= 5'h00;
            num0_reg <= 7'h00;
            num1_reg <= 7'h00;
            best_vld_reg <= 1'b0;
            state_reg <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          pipe_vld_reg <= 1'b1;
          pipe_bank_reg <= scan_reg;
          if (scan_reg == `CAF_LAST_BANK) begin
            state_reg <= ST_DRAIN;
          end else begin
            scan_reg <= scan_reg + 5'h01;
          end
        end
        ST_DRAIN: begin
          pipe_vld_reg <= 1'b0;
          state_reg <= ST_FINISH;
        end
        ST_FINISH: begin
          // queue and number travel with the frame
          accept_valid <= best_vld_reg;
          accept_queue <= best_queue_reg;
          accept_index <= best_idx_reg;
          reject_valid <= ~best_vld_reg;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // index queues
  wire [8:0] q_status [0:1];
  genvar gq;
  generate
    for (gq = 0; gq < 2; gq = gq + 1) begin : g_queue
      reg [6:0] slot0_reg, slot1_reg, slot2_reg;
      reg [1:0] cnt_reg;
      reg ovr_reg;
      // only the routed queue takes the frame
      wire push = accept_valid & (accept_queue == gq);
      wire pop = queue_release[gq] & (cnt_reg != 2'h0);
      wire push_ok = push & ((cnt_reg != `CAF_Q_DEPTH) | pop);
      wire [1:0] wpos = pop ? (cnt_reg - 2'h1) : cnt_reg;

      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          slot0_reg <= 7'h00;
          slot1_reg <= 7'h00;
          slot2_reg <= 7'h00;
          cnt_reg <= 2'h0;
          ovr_reg <= 1'b0;
        end else begin
          ovr_reg <= push & ~push_ok;
          if (pop) begin
            slot0_reg <= slot1_reg;
            slot1_reg <= slot2_reg;
          end
          if (push_ok) begin
            case (wpos)
              2'h0: slot0_reg <= accept_index;
              2'h1: slot1_reg <= accept_index;
              default: slot2_reg <= accept_index;
            endcase
          end
          cnt_reg <= cnt_reg + {1'b0, push_ok} - {1'b0, pop};
        end
      end
      // head number in the status field
      assign q_status[gq] = {cnt_reg, (cnt_reg != 2'h0) ? slot0_reg : 7'h00};
      assign queue_overrun[gq] = ovr_reg;
    end
  endgenerate

  assign rx_fifo_status_q0 = q_status[0];
  assign rx_fifo_status_q1 = q_status[1];
endmodule // caf_filter_top

/* File: verif/caf_filter_checker.sv */
`timescale 1ns/1ps
module caf_filter_checker (
  input wire sys_clk,
  input wire resetn,
  input wire frame_valid,
  input wire frame_ready,
  input wire accept_valid,
  input wire accept_queue,
  input wire [6:0] accept_index,
  input wire reject_valid,
  input wire [1:0] queue_release,
  input wire [8:0] rx_fifo_status_q0,
  input wire [8:0] rx_fifo_status_q1,
  input wire [1:0] queue_overrun
);
  wire [1:0] cnt0 = rx_fifo_status_q0[8:7];
  wire [1:0] cnt1 = rx_fifo_status_q1[8:7];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // answer timing
  a_answer_delay: assert property (frame_valid && frame_ready |-> ##31 (accept_valid ^ reject_valid))
    else $error("no answer 31 cycles after frame taken");
  a_busy_hold: assert property (frame_valid && frame_ready |=> !frame_ready [*8])
    else $error("ready rose too early");
  a_single_pulse: assert property (accept_valid || reject_valid |=> !accept_valid && !reject_valid)
    else $error("answer pulse longer than one cycle");
  a_ready_answer: assert property (accept_valid || reject_valid |-> frame_ready)
    else $error("not ready with answer");
  // ==========================================================
  // queue status
  a_status_push: assert property (accept_valid && !accept_queue && cnt0 == 2'h0 && !queue_release[0]
    |=> rx_fifo_status_q0 == {2'h1, $past(accept_index)})
    else $error("queue zero head not loaded");
  a_pop_count: assert property (queue_release[1] && cnt1 != 2'h0 && !(accept_valid && accept_queue)
    |=> cnt1 == $past(cnt1) - 2'h1)
    else $error("queue one pop count wrong");
  a_overrun_flag: assert property (accept_valid && accept_queue && cnt1 == 2'h3 && !queue_release[1]
    |=> queue_overrun[1] && cnt1 == 2'h3)
    else $error("queue one overrun missing");
  a_empty_zero: assert property (cnt0 == 2'h0 |-> rx_fifo_status_q0[6:0] == 7'h00)
    else $error("empty queue shows a number");
endmodule // caf_filter_checker
bind caf_filter_top caf_filter_checker chk (.sys_clk(sys_clk), .resetn(resetn),
  .frame_valid(frame_valid), .frame_ready(frame_ready), .accept_valid(accept_valid),
  .accept_queue(accept_queue), .accept_index(accept_index), .reject_valid(reject_valid),
  .queue_release(queue_release), .rx_fifo_status_q0(rx_fifo_status_q0),
  .rx_fifo_status_q1(rx_fifo_status_q1), .queue_overrun(queue_overrun));

/* File: verif/caf_rx_model.sv */
`timescale 1ns/1ps
module caf_rx_model (
  input wire sys_clk,
  input wire go,
  input wire [10:0] sid_in,
  input wire frame_ready,
  output logic frame_valid,
  output logic [10:0] standard_identifier,
  output logic [17:0] extended_identifier,
  output logic frame_format_bit,
  output logic frame_type_bit
);
  initial begin
    frame_valid = 1'b0;
    {standard_identifier, extended_identifier, frame_format_bit, frame_type_bit} = 31'h0;
  end
  // offer held until taken, then identifier lines scrambled
  always @(posedge sys_clk) begin
    if (frame_valid && frame_ready) begin
      frame_valid <= 1'b0;
      standard_identifier <= ~standard_identifier;
      extended_identifier <= ~extended_identifier;
    end else if (go) begin
      frame_valid <= 1'b1;
      standard_identifier <= sid_in;
      {extended_identifier, frame_format_bit, frame_type_bit} <= 20'h0;
    end
  end
endmodule // caf_rx_model

/* File: verif/test_can_acceptance_filter.sv */
`timescale 1ns/1ps
module test_can_acceptance_filter;
  logic sys_clk = 1'b0, resetn = 1'b0, cfg_wr_en = 1'b0, cfg_wr_word = 1'b0, go = 1'b0;
  logic [4:0] cfg_wr_bank = 5'h00;
  logic [31:0] cfg_wr_data = 32'h0;
  logic [27:0] bank_active = 28'h0000000;
  logic [1:0] queue_release = 2'h0;
  logic [10:0] sid_in = 11'h000;
  wire frame_valid, frame_ready, ff, ft, accept_valid, accept_queue, reject_valid;
  wire [10:0] sid;
  wire [17:0] eid;
  wire [6:0] accept_index;
  wire [8:0] st0, st1;
  wire [1:0] queue_overrun;
  logic [1:0] last_ovr;
  integer fails = 0, samples_checked = 0, cycles = 0;
  always #25 sys_clk = ~sys_clk;
  caf_rx_model rx (.sys_clk(sys_clk), .go(go), .sid_in(sid_in), .frame_ready(frame_ready),
    .frame_valid(frame_valid), .standard_identifier(sid), .extended_identifier(eid),
    .frame_format_bit(ff), .frame_type_bit(ft));
  caf_filter_top dut (.sys_clk(sys_clk), .resetn(resetn), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_bank(cfg_wr_bank), .cfg_wr_word(cfg_wr_word), .cfg_wr_data(cfg_wr_data),
    .bank_scale_32(28'h0000073), .bank_list_mode(28'h0000006), .bank_to_queue_one(28'h000001C),
    .bank_active(bank_active), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .standard_identifier(sid), .extended_identifier(eid), .frame_format_bit(ff),
    .frame_type_bit(ft), .accept_valid(accept_valid), .accept_queue(accept_queue),
    .accept_index(accept_index), .reject_valid(reject_valid), .queue_release(queue_release),
    .rx_fifo_status_q0(st0), .rx_fifo_status_q1(st1), .queue_overrun(queue_overrun));
  // ==========================================================
  // helpers
  function automatic [31:0] w32(input [10:0] s);
    w32 = {s, 21'h0};
  endfunction
  function automatic [15:0] h16(input [10:0] s);
    h16 = {s, 5'h00};
  endfunction
  task automatic chk(input [8:0] got, input [8:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input [4:0] b, input w, input [31:0] d);
    @(posedge sys_clk);
    cfg_wr_en <= 1'b1;
    cfg_wr_bank <= b;
    cfg_wr_word <= w;
    cfg_wr_data <= d;
    @(posedge sys_clk);
    cfg_wr_en <= 1'b0;
  endtask
  // expected code: {accepted, queue, index}, zero for a discarded frame
  task automatic send(input [10:0] s, input [8:0] exp);
    integer n;
    @(posedge sys_clk);
    go <= 1'b1; sid_in <= s;
    @(posedge sys_clk);
    go <= 1'b0;
    for (n = 0; n < 40 && accept_valid !== 1'b1 && reject_valid !== 1'b1; n = n + 1) begin
      @(posedge sys_clk); #1;
    end
    chk(accept_valid === 1'b1 ? {1'b1, accept_queue, accept_index} :
        (reject_valid === 1'b1 ? 9'h000 : 9'h1FF), exp);
    @(posedge sys_clk); #1;
    last_ovr = queue_overrun;
  endtask
  task automatic rel(input [1:0] m);
    @(posedge sys_clk);
    queue_release <= m;
    @(posedge sys_clk);
    queue_release <= 2'h0;
    #1;
  endtask
  task automatic complete_run;
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      complete_run;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    wr(5'h00, 1'b0, w32(11'h123));
    wr(5'h00, 1'b1, {11'h7FF, 21'h0});
    wr(5'h01, 1'b0, w32(11'h123));
    wr(5'h01, 1'b1, w32(11'h200));
    wr(5'h02, 1'b0, {h16(11'h111), h16(11'h123)});
    wr(5'h02, 1'b1, {h16(11'h112), h16(11'h300)});
    wr(5'h03, 1'b0, {16'hFFE0, h16(11'h555)});
    wr(5'h03, 1'b1, {16'hFFE0, h16(11'h556)});
    wr(5'h04, 1'b0, w32(11'h400));
    wr(5'h04, 1'b1, {11'h7FF, 21'h0});
    wr(5'h05, 1'b0, w32(11'h201));
    wr(5'h05, 1'b1, {11'h7F0, 21'h0});
    wr(5'h06, 1'b0, w32(11'h201));
    wr(5'h06, 1'b1, {11'h7FF, 21'h0});
    // bank 3 and the unused banks stay off
    bank_active <= 28'h0000077;
    send(11'h123, 9'h101);
    send(11'h201, 9'h103);
    send(11'h300, 9'h182);
    send(11'h400, 9'h186);
    send(11'h555, 9'h000);
    bank_active <= 28'h000007F;
    send(11'h555, 9'h184);
    chk(st0, {2'h2, 7'h01});
    chk(st1, {2'h3, 7'h02});
    send(11'h300, 9'h182);
    chk({7'h00, last_ovr}, 9'h002);
    rel(2'h2);
    chk(st1, {2'h2, 7'h06});
    rel(2'h3);
    chk(st0, {2'h1, 7'h03});
    chk(st1, {2'h1, 7'h04});
    rel(2'h2);
    chk(st1, 9'h000);
    complete_run;
  end
endmodule // test_can_acceptance_filter
